//--- poe_bcd_check.v
`include "poe_map.vh"
module poe_bcd_check (
    clk_sys,
    reset,
    ptr,
    large_cpu,
    ok,
    bin_val
);
    input wire clk_sys;
    input wire reset;
    input wire [15:0] ptr;
    input wire large_cpu;
    output reg ok;
    output reg [15:0] bin_val;

    wire digits_ok;
    wire [15:0] lim;
    wire [15:0] conv;

    assign digits_ok = (ptr[15:12] < 4'hA) && (ptr[11:8] < 4'hA) &&
                       (ptr[7:4] < 4'hA) && (ptr[3:0] < 4'hA);
    assign lim = large_cpu ? `POE_BCD_MAX_LARGE : `POE_BCD_MAX_SMALL;
    assign conv = {12'h000, ptr[15:12]} * 16'd1000 + {12'h000, ptr[11:8]} * 16'd100 +
                  {12'h000, ptr[7:4]} * 16'd10 + {12'h000, ptr[3:0]};

    // ----------------------------------------
    // Registered BCD validity and conversion
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            ok <= 1'b0;
            bin_val <= 16'h0000;
        end
        else
        begin
            ok <= digits_ok && (ptr <= lim) && (conv < `POE_IND_WINDOW);
            bin_val <= conv;
        end
    end
endmodule

//--- poe_edge_mem.v
`include "poe_map.vh"
module poe_edge_mem (
    clk_sys,
    reset,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input wire clk_sys;
    input wire reset;
    input wire wr_en;
    input wire [4:0] wr_addr;
    input wire wr_data;
    input wire [4:0] rd_addr;
    output reg rd_data;

    reg [`POE_EDGE_SLOTS-1:0] cond_q;

    // ----------------------------------------
    // Per-instruction last-scan condition store
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            cond_q <= {`POE_EDGE_SLOTS{1'b0}};
            rd_data <= 1'b0;
        end
        else
        begin
            if (wr_en)
                cond_q[wr_addr] <= wr_data;
            rd_data <= cond_q[rd_addr];
        end
    end
endmodule

//--- poe_exec.v
// Overview of operation
// - Bad operand or failed execution raises the execution error flag.
// - With the error flag set, normal instructions are suppressed.
// - Setup input picks decimal-coded or binary pointer interpretation.
// - Decimal pointer must be BCD up to 8191 or 9999 by CPU size.
// - Decimal indirection reaches only the first 10,000 words of an area.
// - Decimal pointer names a word in same area; its content is operand.
// - Binary pointer is a full 16-bit address 0000 to FFFF.
// - Plain variant executes every scan with condition true.
// - Rising variant executes once on false-to-true only.
// - Falling variant executes once on true-to-false only.
// - Edges compare against the slot's own condition at its last scan.
// - Edge variants on constant or first-cycle flags never execute.
// - Edge and plain forms share operands and codes; only variant differs.
// - Pulse outputs set target bit after matching edge; it holds until the next scan start.
// - Edge qualification and immediate refresh combine in one instruction.
// - Immediate refresh samples inputs before and writes outputs after.
// - Word operand refreshes whole word; bit operand refreshes its byte.
// - No immediate refresh for points on remote slave racks.
// - First word carries instruction and definers; operands follow.
// - Execution error flag is auxiliary bit A50003, readable by program.
`include "poe_map.vh"
module poe_exec (
    clk_sys,
    reset,
    setup_bin_ind,
    large_cpu,
    ext_area_present,
    instr_valid,
    instr_word,
    operand_word,
    operand_kind,
    exec_cond,
    cond_src,
    scan_start,
    remote_slave,
    mem_rd_data,
    io_in_data,
    instr_done,
    mem_rd_en,
    mem_rd_addr,
    mem_wr_en,
    mem_wr_addr,
    mem_wr_data,
    io_in_req,
    io_out_req,
    io_byte_mode,
    io_byte_hi,
    pulse_bit_set,
    exec_error_flag,
    exec_fire
);
    input wire clk_sys;
    input wire reset;
    input wire setup_bin_ind;
    input wire large_cpu;
    input wire ext_area_present;
    input wire instr_valid;
    input wire [15:0] instr_word;
    input wire [15:0] operand_word;
    input wire [1:0] operand_kind;
    input wire exec_cond;
    input wire [15:0] cond_src;
    input wire scan_start;
    input wire remote_slave;
    input wire [15:0] mem_rd_data;
    input wire [15:0] io_in_data;
    output reg instr_done;
    output reg mem_rd_en;
    output reg [15:0] mem_rd_addr;
    output reg mem_wr_en;
    output reg [15:0] mem_wr_addr;
    output reg [15:0] mem_wr_data;
    output reg io_in_req;
    output reg io_out_req;
    output reg io_byte_mode;
    output reg io_byte_hi;
    output reg pulse_bit_set;
    output reg exec_error_flag;
    output reg exec_fire;

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_PTR = 3'd1;
    localparam [2:0] ST_CHK = 3'd2;
    localparam [2:0] ST_FETCH = 3'd3;
    localparam [2:0] ST_EXEC = 3'd4;
    localparam [2:0] ST_DONE = 3'd5;

    reg [2:0] state_q;
    reg [15:0] instr_q;
    reg [15:0] opnd_q;
    reg [1:0] kind_q;
    reg cond_q;
    reg fixed_src_q;
    reg remote_q;
    reg [15:0] data_q;
    reg go_q;
    reg [1:0] wait_q;
    reg err_pend_q;

    wire [7:0] opc;
    wire [1:0] var_sel;
    wire imm;
    wire [4:0] slot;
    wire prev_cond;
    wire bcd_ok;
    wire [15:0] bcd_val;
    wire edge_pass;
    wire is_pulse;

    assign opc = instr_q[`POE_OPC_HI:`POE_OPC_LO];
    assign var_sel = instr_q[`POE_VAR_HI:`POE_VAR_LO];
    assign imm = instr_q[`POE_IMM_BIT];
    assign slot = instr_q[`POE_DEF_HI:`POE_DEF_LO];
    assign is_pulse = (opc == `POE_OP_PULSE_UP) || (opc == `POE_OP_PULSE_DN);

    // ----------------------------------------
    // Edge qualification
    // ----------------------------------------
    function edge_ok;
        input [1:0] v;
        input prev;
        input cur;
        input fixed;
        begin
            if (v == `POE_VAR_UP)
                edge_ok = !fixed && !prev && cur;
            else if (v == `POE_VAR_DOWN)
                edge_ok = !fixed && prev && !cur;
            else
                edge_ok = cur;
        end
    endfunction

    function is_fixed_flag;
        input [15:0] a;
        begin
            is_fixed_flag = (a == `POE_FLAG_ALWAYS_ON) || (a == `POE_FLAG_ALWAYS_OFF) ||
                            (a == `POE_FLAG_FIRST_CYC);
        end
    endfunction

    // Pulse instructions carry their edge in the opcode
    wire [1:0] eff_var;
    assign eff_var = (opc == `POE_OP_PULSE_UP) ? `POE_VAR_UP :
                     (opc == `POE_OP_PULSE_DN) ? `POE_VAR_DOWN : var_sel;
    assign edge_pass = edge_ok(eff_var, prev_cond, cond_q, fixed_src_q);

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    poe_edge_mem u_edge (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(state_q == ST_CHK),
        .wr_addr(slot),
        .wr_data(cond_q),
        .rd_addr(slot),
        .rd_data(prev_cond)
    );

    poe_bcd_check u_bcd (
        .clk_sys(clk_sys),
        .reset(reset),
        .ptr(mem_rd_data),
        .large_cpu(large_cpu),
        .ok(bcd_ok),
        .bin_val(bcd_val)
    );

    // ----------------------------------------
    // Execution sequencer
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            instr_q <= 16'h0000;
            opnd_q <= 16'h0000;
            kind_q <= `POE_OPK_DIRECT;
            cond_q <= 1'b0;
            fixed_src_q <= 1'b0;
            remote_q <= 1'b0;
            data_q <= 16'h0000;
            go_q <= 1'b0;
            wait_q <= 2'h0;
            err_pend_q <= 1'b0;
            instr_done <= 1'b0;
            mem_rd_en <= 1'b0;
            mem_rd_addr <= 16'h0000;
            mem_wr_en <= 1'b0;
            mem_wr_addr <= 16'h0000;
            mem_wr_data <= 16'h0000;
            io_in_req <= 1'b0;
            io_out_req <= 1'b0;
            io_byte_mode <= 1'b0;
            io_byte_hi <= 1'b0;
            pulse_bit_set <= 1'b0;
            exec_error_flag <= `POE_ERR_RESET;
            exec_fire <= 1'b0;
        end
        else
        begin
            instr_done <= 1'b0;
            mem_rd_en <= 1'b0;
            mem_wr_en <= 1'b0;
            io_in_req <= 1'b0;
            io_out_req <= 1'b0;
            exec_fire <= 1'b0;
            if (scan_start)
                pulse_bit_set <= 1'b0;
            if (scan_start && state_q == ST_IDLE)
                exec_error_flag <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (instr_valid)
                    begin
                        instr_q <= instr_word;
                        opnd_q <= operand_word;
                        kind_q <= operand_kind;
                        cond_q <= exec_cond;
                        fixed_src_q <= is_fixed_flag(cond_src);
                        remote_q <= remote_slave;
                        err_pend_q <= 1'b0;
                        state_q <= ST_PTR;
                    end
                end
                ST_PTR:
                begin
                    // Fetch pointer word of the indirect operand
                    if (kind_q == `POE_OPK_IND_EXT && !ext_area_present)
                        err_pend_q <= 1'b1;
                    if (kind_q == `POE_OPK_IND_DATA || kind_q == `POE_OPK_IND_EXT)
                    begin
                        mem_rd_en <= 1'b1;
                        mem_rd_addr <= opnd_q;
                    end
                    wait_q <= 2'h0;
                    state_q <= ST_CHK;
                end
                ST_CHK:
                begin
                    // Edge memory has been read here; the slot is written at the end of this state
                    go_q <= edge_pass && !exec_error_flag;
                    if (imm && remote_q)
                        err_pend_q <= 1'b1;
                    if (kind_q == `POE_OPK_IND_DATA || kind_q == `POE_OPK_IND_EXT)
                        state_q <= ST_FETCH;
                    else
                    begin
                        data_q <= opnd_q;
                        state_q <= ST_EXEC;
                    end
                end
                ST_FETCH:
                begin
                    wait_q <= wait_q + 2'h1;
                    if (wait_q == 2'h0 && setup_bin_ind)
                    begin
                        mem_rd_en <= 1'b1;
                        mem_rd_addr <= mem_rd_data;
                    end
                    else if (wait_q == 2'h1 && !setup_bin_ind)
                    begin
                        if (!bcd_ok)
                            err_pend_q <= 1'b1;
                        mem_rd_en <= 1'b1;
                        // Same area: keep the area base, add the word number
                        mem_rd_addr <= (opnd_q & 16'hC000) | bcd_val;
                    end
                    // Binary operand returns at wait 2, decimal one step later
                    else if ((wait_q == 2'h2 && setup_bin_ind) || wait_q == 2'h3)
                    begin
                        data_q <= mem_rd_data;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    if (err_pend_q)
                        exec_error_flag <= 1'b1;
                    else if (go_q)
                    begin
                        exec_fire <= 1'b1;
                        if (is_pulse)
                            pulse_bit_set <= 1'b1;
                        if (imm)
                        begin
                            io_in_req <= 1'b1;
                            io_byte_mode <= (opc == `POE_OP_BIT_OUT) || is_pulse;
                            io_byte_hi <= instr_q[3];
                        end
                        if (opc == `POE_OP_WORD_MOVE)
                        begin
                            mem_wr_en <= 1'b1;
                            mem_wr_addr <= instr_q;
                            mem_wr_data <= imm ? io_in_data : data_q;
                        end
                    end
                    state_q <= ST_DONE;
                end
                ST_DONE:
                begin
                    if (imm && go_q && !err_pend_q)
                        io_out_req <= 1'b1;
                    instr_done <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- poe_exec_checker.sv
`include "poe_map.vh"
module poe_exec_checker (
    input wire clk_sys,
    input wire reset,
    input wire setup_bin_ind,
    input wire large_cpu,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire [15:0] operand_word,
    input wire [1:0] operand_kind,
    input wire exec_cond,
    input wire [15:0] cond_src,
    input wire scan_start,
    input wire remote_slave,
    input wire [15:0] mem_rd_data,
    input wire instr_done,
    input wire mem_rd_en,
    input wire [15:0] mem_rd_addr,
    input wire mem_wr_en,
    input wire io_in_req,
    input wire io_out_req,
    input wire pulse_bit_set,
    input wire exec_error_flag,
    input wire exec_fire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q, cond_q, prev_q, fix_q, pls_q, rem_q;
    logic [1:0] var_q;
    logic [31:0] edge_q;
    wire take = instr_valid && (!busy_q || instr_done);
    wire ind = operand_kind == `POE_OPK_IND_DATA;
    wire fix = cond_src == `POE_FLAG_ALWAYS_ON || cond_src == `POE_FLAG_ALWAYS_OFF
        || cond_src == `POE_FLAG_FIRST_CYC;
    wire gate = var_q == `POE_VAR_PLAIN ? cond_q : var_q == `POE_VAR_UP ?
        cond_q && !prev_q && !fix_q : !cond_q && prev_q && !fix_q;

    function automatic logic bcd_ok(input logic [15:0] v, input logic big);
        logic ok;
        ok = v <= (big ? 16'h9999 : 16'h8191);
        for (int i = 0; i < 4; i++)
            ok = ok && v[i*4 +: 4] <= 4'h9;
        return ok;
    endfunction

    // Per-slot condition history, updated whenever a slot is scanned
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            busy_q <= 1'b0;
            edge_q <= 32'h0;
        end
        else if (take)
        begin
            busy_q <= 1'b1;
            var_q <= instr_word[`POE_VAR_HI:`POE_VAR_LO];
            cond_q <= exec_cond;
            prev_q <= edge_q[instr_word[4:0]];
            fix_q <= fix;
            pls_q <= instr_word[15:8] == `POE_OP_PULSE_UP ||
                instr_word[15:8] == `POE_OP_PULSE_DN;
            rem_q <= remote_slave;
            edge_q[instr_word[4:0]] <= exec_cond;
        end
        else if (instr_done)
            busy_q <= 1'b0;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_bin_ptr;
        take && ind && setup_bin_ind ##2 mem_rd_en ##1 1'b1;
    endsequence
    sequence s_bad_ptr;
        take && ind && !setup_bin_ind ##2 mem_rd_en ##1 !bcd_ok(mem_rd_data, large_cpu);
    endsequence

    a_no_fire_err: assert property (exec_fire |-> !exec_error_flag)
        else $error("fire while error flag set");
    a_edge_gate: assert property (exec_fire && !pls_q |-> gate)
        else $error("fire without qualifying condition");
    a_err_holds: assert property (exec_error_flag && !scan_start |=> exec_error_flag)
        else $error("error flag dropped without scan start");
    a_done_bound: assert property (take |-> ##[4:9] instr_done)
        else $error("instruction not completed in time");
    a_ptr_read: assert property (take && ind |-> ##2 mem_rd_en &&
        mem_rd_addr == $past(operand_word, 2))
        else $error("pointer word not read");
    a_bin_fetch: assert property (s_bin_ptr |=> mem_rd_en && mem_rd_addr == $past(mem_rd_data))
        else $error("binary pointer not used as address");
    a_bad_ptr_err: assert property (s_bad_ptr |-> ##[1:5] exec_error_flag)
        else $error("bad pointer did not raise error");
    a_bad_ptr_skip: assert property (s_bad_ptr |=> (!exec_fire && !mem_wr_en) [*5])
        else $error("bad pointer instruction executed");
    a_pulse_hold: assert property (pulse_bit_set && !scan_start |=> pulse_bit_set)
        else $error("pulse bit dropped early");
    a_remote_io: assert property (io_in_req || io_out_req |-> !rem_q)
        else $error("refresh on remote slave point");
    a_imm_order: assert property (io_in_req |=> io_out_req)
        else $error("output refresh not after input refresh");
endmodule

bind poe_exec poe_exec_checker u_chk (
    .clk_sys, .reset, .setup_bin_ind, .large_cpu, .instr_valid, .instr_word, .operand_word,
    .operand_kind, .exec_cond, .cond_src, .scan_start, .remote_slave, .mem_rd_data,
    .instr_done, .mem_rd_en, .mem_rd_addr, .mem_wr_en, .io_in_req, .io_out_req,
    .pulse_bit_set, .exec_error_flag, .exec_fire
);

//--- poe_map.vh
`ifndef POE_MAP_VH
`define POE_MAP_VH
// ----------------------------------------
// Variant encodings
// ----------------------------------------
`define POE_VAR_PLAIN 2'h0
`define POE_VAR_UP 2'h1
`define POE_VAR_DOWN 2'h2
// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define POE_OPC_HI 15
`define POE_OPC_LO 8
`define POE_VAR_HI 7
`define POE_VAR_LO 6
`define POE_IMM_BIT 5
`define POE_DEF_HI 4
`define POE_DEF_LO 0
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define POE_OP_PULSE_UP 8'h0D
`define POE_OP_PULSE_DN 8'h0E
`define POE_OP_WORD_MOVE 8'h1E
`define POE_OP_BIT_OUT 8'h20
// ----------------------------------------
// Operand kinds
// ----------------------------------------
`define POE_OPK_DIRECT 2'h0
`define POE_OPK_IND_DATA 2'h1
`define POE_OPK_IND_EXT 2'h2
`define POE_OPK_CONST 2'h3
// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define POE_BCD_MAX_SMALL 16'h8191
`define POE_BCD_MAX_LARGE 16'h9999
`define POE_IND_WINDOW 16'd10000
`define POE_EDGE_SLOTS 32
`define POE_FLAG_ALWAYS_ON 16'hA50D
`define POE_FLAG_ALWAYS_OFF 16'hA50E
`define POE_FLAG_FIRST_CYC 16'hA50F
`define POE_ERR_FLAG_ADDR 16'hA503
`define POE_ERR_RESET 1'b0
`endif

//--- poe_mem_model.sv
module poe_mem_model (
    input wire clk_sys,
    input wire mem_rd_en,
    input wire [15:0] mem_rd_addr,
    input wire mem_wr_en,
    input wire [15:0] mem_wr_addr,
    input wire [15:0] mem_wr_data,
    input wire io_in_req,
    output logic [15:0] mem_rd_data,
    output logic [15:0] io_in_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:65535];
    // Read data valid one cycle after the strobe, toggles otherwise
    // Input image stands between refreshes and flips after each one
    always @(posedge clk_sys)
    begin
        mem_rd_data <= mem_rd_en ? mem[mem_rd_addr] : ~mem_rd_data;
        if (io_in_req)
            io_in_data <= ~io_in_data;
        if (mem_wr_en)
            mem[mem_wr_addr] <= mem_wr_data;
    end
    initial
    begin
        mem_rd_data = 16'h0000;
        io_in_data = 16'h5AA5;
    end
endmodule

//--- tb_top.sv
`include "poe_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] mv = `POE_OP_WORD_MOVE;
    logic clk_sys = 1'b0, reset = 1'b1, setup_bin_ind = 1'b0, large_cpu = 1'b0;
    logic ext_area_present = 1'b1, instr_valid = 1'b0, exec_cond = 1'b0;
    logic scan_start = 1'b0, remote_slave = 1'b0, bm;
    logic [15:0] instr_word = 16'h0000, operand_word = 16'h0000, cond_src = 16'h0100, wd;
    logic [1:0] operand_kind = 2'h0;
    wire [15:0] mem_rd_data, io_in_data, mem_rd_addr, mem_wr_addr, mem_wr_data;
    wire instr_done, mem_rd_en, mem_wr_en, io_in_req, io_out_req, io_byte_mode, io_byte_hi;
    wire pulse_bit_set, exec_error_flag, exec_fire;
    int err_total = 0, num_checks = 0, cyc = 0, nf, nw, nin, nout;

    always #4 clk_sys = ~clk_sys;

    poe_exec DUT (.clk_sys, .reset, .setup_bin_ind, .large_cpu, .ext_area_present,
        .instr_valid, .instr_word, .operand_word, .operand_kind, .exec_cond, .cond_src,
        .scan_start, .remote_slave, .mem_rd_data, .io_in_data, .instr_done, .mem_rd_en,
        .mem_rd_addr, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .io_in_req, .io_out_req,
        .io_byte_mode, .io_byte_hi, .pulse_bit_set, .exec_error_flag, .exec_fire);
    poe_mem_model PRT (.clk_sys, .mem_rd_en, .mem_rd_addr, .mem_wr_en, .mem_wr_addr,
        .mem_wr_data, .io_in_req, .mem_rd_data, .io_in_data);

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [15:0] iw(input logic [7:0] o, input logic [1:0] v, input logic m,
        input logic [4:0] s);
        return {o, v, m, s};
    endfunction

    task automatic issue(input logic [15:0] w, input logic [15:0] op, input logic [1:0] k,
        input logic c);
        nf = 0;
        nw = 0;
        nin = 0;
        nout = 0;
        instr_word = w;
        operand_word = op;
        operand_kind = k;
        exec_cond = c;
        instr_valid = 1'b1;
        @(posedge clk_sys);
        #1 instr_valid = 1'b0;
        for (int n = 0; n < 12; n++)
        begin
            nf += (exec_fire === 1'b1);
            nw += (mem_wr_en === 1'b1);
            nin += (io_in_req === 1'b1);
            nout += (io_out_req === 1'b1);
            if (mem_wr_en === 1'b1)
                wd = mem_wr_data;
            if (io_out_req === 1'b1)
                bm = io_byte_mode;
            if (instr_done === 1'b1)
                break;
            @(posedge clk_sys);
            #1;
        end
        check("done", instr_done, 1'b1);
    endtask

    task automatic scan();
        scan_start = 1'b1;
        @(posedge clk_sys);
        #1 scan_start = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    // Slots 0..2 interleaved so each form must keep its own history
    task automatic t_edge();
        logic [4:0] cs = 5'b00110;
        logic [4:0] ex [3] = '{5'b00110, 5'b00010, 5'b01000};
        for (int j = 0; j < 5; j++)
            for (int i = 0; i < 3; i++)
            begin
                issue(iw(mv, i[1:0], 1'b0, i[4:0]), 16'h0007, `POE_OPK_CONST, cs[j]);
                check("fire", nf, ex[i][j]);
            end
    endtask

    task automatic t_fixed();
        logic [15:0] f [3] = '{`POE_FLAG_ALWAYS_ON, `POE_FLAG_ALWAYS_OFF, `POE_FLAG_FIRST_CYC};
        for (int i = 0; i < 6; i++)
        begin
            cond_src = f[i / 2];
            issue(iw(mv, `POE_VAR_UP, 1'b0, 5'h09), 16'h0007, `POE_OPK_CONST, i[0]);
            check("fixed up", nf, 0);
            issue(iw(mv, `POE_VAR_DOWN, 1'b0, 5'h0A), 16'h0007, `POE_OPK_CONST, !i[0]);
            check("fixed down", nf, 0);
        end
        cond_src = 16'h0100;
    endtask

    task automatic t_pulse();
        for (int i = 0; i < 6; i++)
        begin
            issue(iw(i < 3 ? `POE_OP_PULSE_UP : `POE_OP_PULSE_DN, 2'h0, 1'b0,
                i < 3 ? 5'h0C : 5'h10), 16'h0040, `POE_OPK_DIRECT, (i % 3 != 0) ^ (i > 2));
            check("pulse", pulse_bit_set, i % 3 == 1);
            scan();
            check("pulse clear", pulse_bit_set, 0);
        end
    endtask

    task automatic t_bcd();
        logic [15:0] p [5] = '{16'h2222, 16'h12A4, 16'h8192, 16'h8192, 16'h9999};
        logic [15:0] a [5] = '{16'h08AE, 16'h0000, 16'h0000, 16'h2000, 16'h270F};
        logic e [5] = '{0, 1, 1, 0, 0};
        setup_bin_ind = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            large_cpu = i > 2;
            PRT.mem[1] = p[i];
            PRT.mem[a[i]] = 16'h5550 + 16'(i);
            issue(iw(mv, 2'h0, 1'b0, 5'h0D), 16'h0001, `POE_OPK_IND_DATA, 1'b1);
            check("error", exec_error_flag, e[i]);
            check("writes", nw, !e[i]);
            if (!e[i])
                check("data", wd, 16'h5550 + 16'(i));
            scan();
        end
        ext_area_present = 1'b0;
        issue(iw(mv, 2'h0, 1'b0, 5'h0E), 16'h0001, `POE_OPK_IND_EXT, 1'b1);
        check("ext error", exec_error_flag, 1);
        issue(iw(mv, 2'h0, 1'b0, 5'h0E), 16'h0007, `POE_OPK_CONST, 1'b1);
        check("blocked", nf, 0);
        check("held", exec_error_flag, 1);
        scan();
        check("cleared", exec_error_flag, 0);
        ext_area_present = 1'b1;
    endtask

    task automatic t_bin();
        logic [15:0] p [2] = '{16'h0A00, 16'hFFFF};
        logic [15:0] d [2] = '{16'h8014, 16'h0F0F};
        setup_bin_ind = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            PRT.mem[1] = p[i];
            PRT.mem[p[i]] = d[i];
            issue(iw(mv, 2'h0, 1'b0, 5'h0D), 16'h0001, `POE_OPK_IND_DATA, 1'b1);
            check("bin data", wd, d[i]);
            check("bin error", exec_error_flag, 0);
        end
        setup_bin_ind = 1'b0;
    endtask

    task automatic t_imm();
        logic [7:0] o [4] = '{`POE_OP_BIT_OUT, mv, `POE_OP_BIT_OUT, mv};
        for (int i = 0; i < 4; i++)
        begin
            remote_slave = i == 2;
            issue(iw(o[i], i == 3 ? 2'h1 : 2'h0, 1'b1, 5'h0F + i[4:0]), 16'h0030,
                `POE_OPK_DIRECT, 1'b1);
            check("in req", nin, i != 2);
            check("out req", nout, i != 2);
            if (i < 2)
            begin
                check("byte mode", bm, i == 0);
                check("byte hi", io_byte_hi, i == 0);
            end
            if (i == 1)
                check("imm data", wd, 16'hA55A);
            if (i == 2)
                check("remote error", exec_error_flag, 1);
            if (i == 3)
                check("imm edge", nf, 1);
            scan();
        end
        remote_slave = 1'b0;
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1 reset = 1'b0;
        t_edge();
        t_fixed();
        t_pulse();
        t_bcd();
        t_bin();
        t_imm();
        results();
    end
endmodule
